/* File: iov_defs.vh */
// Constants shared by the channel validation, link and swap logic.
`ifndef IOV_DEFS_VH
`define IOV_DEFS_VH

// ****************************************************************
// Register byte offsets on the AHB-Lite bus.
// ****************************************************************
`define IOV_OFF_CTRL 9'h000
`define IOV_OFF_LINK 9'h004
`define IOV_OFF_IRQ_STAT 9'h008
`define IOV_OFF_IRQ_CLR 9'h00C
`define IOV_OFF_IRQ_EN 9'h010
// Settings window base; haddr bit 8 selects it.
`define IOV_WIN_BIT 8

// ****************************************************************
// Field positions.
// ****************************************************************
`define IOV_CTRL_APPLY_BIT 9
`define IOV_CTRL_BUSY_BIT 0
`define IOV_SWAP_BIT 7

// ****************************************************************
// Word layout of one channel inside the settings window.
// ****************************************************************
`define IOV_W_PDSIZE 3'h0
`define IOV_W_TYPE 3'h1
`define IOV_W_VENDOR 3'h2
`define IOV_W_DEVICE 3'h3
`define IOV_W_SER_LAST 3'h7

// ****************************************************************
// Validation types.
// ****************************************************************
`define IOV_VT_DISABLED 2'h0
`define IOV_VT_COMPATIBLE 2'h1
`define IOV_VT_IDENTICAL 2'h2

// ****************************************************************
// Reset values.
// ****************************************************************
`define IOV_RST_WORD 32'h00000000
`define IOV_RST_IRQ 16'h0000

`endif

/* File: iov_mem.v */
// Settings store: staged bank and active bank, registered read data.
`timescale 1ns/100ps
`include "iov_defs.vh"

module iov_mem (
   input wire clk,
   input wire rst_n,
   input wire we,
   input wire [6:0] addr,
   input wire [31:0] wdata,
   output reg [31:0] rdata
);

   // Words 0..63 are staged settings, 64..127 the applied copy.
   reg [31:0] mem [0:127];
   integer i;

   // ****************************************************************
   // Storage with a cleared power-on state.
   // ****************************************************************
   // Reset clears every word so each channel starts with validation off.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < 128; i = i + 1) begin
            mem[i] <= `IOV_RST_WORD;
         end
         rdata <= `IOV_RST_WORD;
      end else begin
         if (we) begin
            mem[addr] <= wdata;
         end
         rdata <= mem[addr];
      end
   end

endmodule

/* File: iov_channel_top.v */
// Eight-channel device validation, disconnection detection and byte swap.
//
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/100ps
`include "iov_defs.vh"
// What this block does
// - Validate by type: disabled, compatible, identical.
// - Validation type held and written per channel.
// - Line indicator shows validation outcome.
// - Identity words readable only when validation on.
// - Validation settings load on apply request.
// - Detect communication loss per channel.
// - Loss clears the channel link-up flag.
// - Disconnection detection always on.
// - Swap bytes of process words both ways.
// - Swap enable is size word bit seven.
// - Swap setting loads on apply request.
// - Settings reset to disabled and zeros.

module iov_channel_top (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg hreadyout,
   output reg hresp,
   output reg [31:0] hrdata,
   input wire [7:0] comm_ok_pin,
   input wire [7:0] iolink_mode_pin,
   input wire id_report_valid,
   input wire [2:0] id_report_ch,
   input wire [15:0] id_report_vendor,
   input wire [31:0] id_report_device,
   input wire [127:0] id_report_serial,
   output reg id_report_ready,
   input wire pd_dev_valid,
   input wire [2:0] pd_dev_ch,
   input wire [15:0] pd_dev_data,
   output reg pd_ctl_valid,
   output reg [2:0] pd_ctl_ch,
   output reg [15:0] pd_ctl_data,
   input wire pd_ctl_in_valid,
   input wire [2:0] pd_ctl_in_ch,
   input wire [15:0] pd_ctl_in_data,
   output reg pd_dev_out_valid,
   output reg [2:0] pd_dev_out_ch,
   output reg [15:0] pd_dev_out_data,
   output reg [7:0] channel_link_up_flags,
   output reg [7:0] channel_line_indicator,
   output reg [7:0] channel_line_fault,
   output reg irq
);

   // ****************************************************************
   // States.
   // ****************************************************************
   localparam B_IDLE = 2'h0;
   localparam B_ACC = 2'h1;
   localparam B_MRD = 2'h2;
   localparam E_IDLE = 2'h0;
   localparam E_RD = 2'h1;
   localparam E_WR = 2'h2;
   localparam V_IDLE = 2'h0;
   localparam V_RD = 2'h1;
   localparam V_CMP = 2'h2;

   // Exchanges the two bytes of a process data word when asked.
   function [15:0] swap_word;
      input [15:0] w;
      input en;
      begin
         swap_word = en ? {w[7:0], w[15:8]} : w;
      end
   endfunction

   reg [1:0] bus_reg;      // Bus data-phase state.
   reg a_mem_reg;          // Captured access targets the settings window.
   reg a_write_reg;        // Captured access is a write.
   reg [5:0] a_idx_reg;    // Captured word index.
   reg [8:0] a_off_reg;    // Captured register offset.
   reg [1:0] eng_reg;      // Apply copy engine state.
   reg [5:0] cnt_reg;      // Copy engine word counter.
   reg apply_pend_reg;     // Apply request waiting for the engine.
   reg [1:0] val_reg;      // Validator state.
   reg [2:0] vch_reg;      // Channel under validation.
   reg [2:0] vw_reg;       // Word under comparison.
   reg [15:0] id_ven_reg;  // Reported vendor identifier.
   reg [31:0] id_dev_reg;  // Reported device identifier.
   reg [127:0] id_ser_reg; // Reported serial words.
   reg [15:0] vtype_reg;   // Applied validation type, two bits a channel.
   reg [7:0] swap_reg;     // Applied swap enables.
   reg [7:0] val_ok_reg;   // Validation passed (or disabled) per channel.
   reg [7:0] val_fail_reg; // Validation mismatch per channel.
   reg [15:0] sync1_reg;   // First synchroniser stage of the pins.
   reg [15:0] sync2_reg;   // Second synchroniser stage.
   reg [7:0] comm_d_reg;   // Previous qualified link state.
   reg [15:0] irq_stat_reg;
   reg [15:0] irq_en_reg;
   reg mem_we;
   reg [6:0] mem_addr;
   reg [31:0] mem_wdata;
   reg [31:0] exp_word;
   reg [31:0] reg_rd;
   wire [31:0] mem_rdata;
   wire free;
   wire [7:0] comm_now;
   wire [1:0] vt_ch;
   wire [1:0] vt_bus;
   wire [2:0] last_w;
   wire [7:0] drop_ev;
   wire reg_wr;          // Register write in its data phase.
   wire [15:0] irq_ev;   // Interrupt events of this cycle.

   assign free = (eng_reg == E_IDLE) && (val_reg == V_IDLE);
   // Link and loss both count only in IO-Link mode; leaving the mode reads as a loss.
   assign comm_now = sync2_reg[7:0] & sync2_reg[15:8];
   assign drop_ev = comm_d_reg & ~comm_now;
   assign reg_wr = (bus_reg == B_ACC) && !a_mem_reg && a_write_reg;
   assign irq_ev = {val_fail_reg & ~channel_line_fault, drop_ev};
   assign vt_ch = vtype_reg[vch_reg*2 +: 2];
   assign vt_bus = vtype_reg[a_idx_reg[5:3]*2 +: 2];
   assign last_w = (vt_ch == `IOV_VT_IDENTICAL) ? `IOV_W_SER_LAST : `IOV_W_DEVICE;

   iov_mem u_mem (
      .clk(hclk),
      .rst_n(hresetn),
      .we(mem_we),
      .addr(mem_addr),
      .wdata(mem_wdata),
      .rdata(mem_rdata)
   );

   // ****************************************************************
   // Settings store arbitration.
   // ****************************************************************
   // Copy engine first, validator next, bus last; the bus stalls instead.
   always @* begin
      mem_we = 1'b0;
      mem_addr = {1'b0, a_idx_reg};
      mem_wdata = hwdata;
      if (eng_reg == E_RD) begin
         mem_addr = {1'b0, cnt_reg};
      end else if (eng_reg == E_WR) begin
         mem_we = 1'b1;
         mem_addr = {1'b1, cnt_reg};
         mem_wdata = mem_rdata;
      end else if (val_reg == V_RD) begin
         mem_addr = {1'b1, vch_reg, vw_reg};
      end else if (bus_reg == B_ACC && a_mem_reg) begin
         mem_we = a_write_reg;
      end
   end

   // Expected value of the word being compared; vendor is 16 bits.
   always @* begin
      case (vw_reg)
         `IOV_W_VENDOR: exp_word = {16'h0000, id_ven_reg};
         `IOV_W_DEVICE: exp_word = id_dev_reg;
         3'h4: exp_word = id_ser_reg[31:0];
         3'h5: exp_word = id_ser_reg[63:32];
         3'h6: exp_word = id_ser_reg[95:64];
         3'h7: exp_word = id_ser_reg[127:96];
         default: exp_word = 32'h00000000;
      endcase
   end

   // Register read mux; unmapped offsets read as zero.
   always @* begin
      case (a_off_reg)
         `IOV_OFF_CTRL: reg_rd = {31'h00000000, ~free};
         `IOV_OFF_LINK: reg_rd = {16'h0000, val_fail_reg, channel_link_up_flags};
         `IOV_OFF_IRQ_STAT: reg_rd = {16'h0000, irq_stat_reg};
         `IOV_OFF_IRQ_EN: reg_rd = {16'h0000, irq_en_reg};
         default: reg_rd = 32'h00000000;
      endcase
   end

   // ****************************************************************
   // AHB-Lite slave.
   // ****************************************************************
   // Every transfer takes one wait state; window reads take two, and
   // any window access waits while an apply or validation is running.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_reg <= B_IDLE;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
         a_mem_reg <= 1'b0;
         a_write_reg <= 1'b0;
         a_idx_reg <= 6'h00;
         a_off_reg <= 9'h000;
      end else begin
         case (bus_reg)
            B_IDLE: begin
               if (hsel && hready && htrans[1]) begin
                  a_mem_reg <= haddr[`IOV_WIN_BIT];
                  a_write_reg <= hwrite;
                  a_idx_reg <= haddr[7:2];
                  a_off_reg <= {1'b0, haddr[7:2], 2'b00};
                  hreadyout <= 1'b0;
                  bus_reg <= B_ACC;
               end
            end
            B_ACC: begin
               if (!a_mem_reg) begin
                  hrdata <= a_write_reg ? 32'h00000000 : reg_rd;
                  hreadyout <= 1'b1;
                  bus_reg <= B_IDLE;
               end else if (free) begin
                  if (a_write_reg) begin
                     hreadyout <= 1'b1;
                     bus_reg <= B_IDLE;
                  end else begin
                     bus_reg <= B_MRD;
                  end
               end
            end
            B_MRD: begin
               // Identity words stay hidden while validation is off.
               if (a_idx_reg[2:0] >= `IOV_W_VENDOR && vt_bus == `IOV_VT_DISABLED) begin
                  hrdata <= 32'h00000000;
               end else begin
                  hrdata <= mem_rdata;
               end
               hreadyout <= 1'b1;
               bus_reg <= B_IDLE;
            end
            default: begin
               hreadyout <= 1'b1;
               bus_reg <= B_IDLE;
            end
         endcase
      end
   end

   // ****************************************************************
   // Apply engine: staged bank copied into the active bank.
   // ****************************************************************
   // Settings written by software do nothing until the apply request;
   // the copy then refreshes type and swap and restarts validation.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         eng_reg <= E_IDLE;
         cnt_reg <= 6'h00;
         apply_pend_reg <= 1'b0;
         vtype_reg <= {8{`IOV_VT_DISABLED}};
         swap_reg <= 8'h00;
      end else begin
         // A request arriving while a copy runs is kept, not lost.
         if (reg_wr && a_off_reg == `IOV_OFF_CTRL && hwdata[`IOV_CTRL_APPLY_BIT]) begin
            apply_pend_reg <= 1'b1;
         end else if (eng_reg == E_IDLE && val_reg == V_IDLE && apply_pend_reg) begin
            apply_pend_reg <= 1'b0;
         end
         case (eng_reg)
            E_IDLE: begin
               if (apply_pend_reg && val_reg == V_IDLE) begin
                  cnt_reg <= 6'h00;
                  eng_reg <= E_RD;
               end
            end
            E_RD: eng_reg <= E_WR;
            E_WR: begin
               if (cnt_reg[2:0] == `IOV_W_PDSIZE) begin
                  swap_reg[cnt_reg[5:3]] <= mem_rdata[`IOV_SWAP_BIT];
               end
               if (cnt_reg[2:0] == `IOV_W_TYPE) begin
                  vtype_reg[cnt_reg[5:3]*2 +: 2] <= mem_rdata[1:0];
               end
               cnt_reg <= cnt_reg + 6'h01;
               eng_reg <= (cnt_reg == 6'h3F) ? E_IDLE : E_RD;
            end
            default: eng_reg <= E_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Validator: compares a reported identity with applied settings.
   // ****************************************************************
   // One identity is held at a time; the ready output throttles the
   // reporter so no report is dropped during a compare or a copy.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         val_reg <= V_IDLE;
         vch_reg <= 3'h0;
         vw_reg <= 3'h0;
         id_ven_reg <= 16'h0000;
         id_dev_reg <= 32'h00000000;
         id_ser_reg <= 128'h0;
         val_ok_reg <= 8'hFF;
         val_fail_reg <= 8'h00;
         id_report_ready <= 1'b0;
      end else begin
         id_report_ready <= free && !apply_pend_reg && !(id_report_valid && id_report_ready);
         if (eng_reg == E_WR && cnt_reg[2:0] == `IOV_W_TYPE) begin
            // New type: disabled passes, others wait for a fresh report.
            val_ok_reg[cnt_reg[5:3]] <= (mem_rdata[1:0] == `IOV_VT_DISABLED);
            val_fail_reg[cnt_reg[5:3]] <= 1'b0;
         end
         case (val_reg)
            V_IDLE: begin
               if (id_report_valid && id_report_ready) begin
                  vch_reg <= id_report_ch;
                  id_ven_reg <= id_report_vendor;
                  id_dev_reg <= id_report_device;
                  id_ser_reg <= id_report_serial;
                  vw_reg <= `IOV_W_VENDOR;
                  if (vtype_reg[id_report_ch*2 +: 2] == `IOV_VT_DISABLED) begin
                     val_ok_reg[id_report_ch] <= 1'b1;
                     val_fail_reg[id_report_ch] <= 1'b0;
                  end else begin
                     val_ok_reg[id_report_ch] <= 1'b0;
                     val_reg <= V_RD;
                  end
               end
            end
            V_RD: val_reg <= V_CMP;
            V_CMP: begin
               if (mem_rdata != exp_word) begin
                  val_fail_reg[vch_reg] <= 1'b1;
                  val_reg <= V_IDLE;
               end else if (vw_reg == last_w) begin
                  val_ok_reg[vch_reg] <= 1'b1;
                  val_fail_reg[vch_reg] <= 1'b0;
                  val_reg <= V_IDLE;
               end else begin
                  vw_reg <= vw_reg + 3'h1;
                  val_reg <= V_RD;
               end
            end
            default: val_reg <= V_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Link flags, indicators and interrupts.
   // ****************************************************************
   // Pins pass two stages; only the second is read by any logic.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg <= 16'h0000;
         sync2_reg <= 16'h0000;
         comm_d_reg <= 8'h00;
         channel_link_up_flags <= 8'h00;
         channel_line_indicator <= 8'h00;
         channel_line_fault <= 8'h00;
         irq_stat_reg <= `IOV_RST_IRQ;
         irq_en_reg <= `IOV_RST_IRQ;
         irq <= 1'b0;
      end else begin
         sync1_reg <= {iolink_mode_pin, comm_ok_pin};
         sync2_reg <= sync1_reg;
         comm_d_reg <= comm_now;
         // Loss or mismatch drops the flag in the same update.
         channel_link_up_flags <= comm_now & val_ok_reg;
         channel_line_indicator <= comm_now & val_ok_reg;
         channel_line_fault <= val_fail_reg;
         if (reg_wr && a_off_reg == `IOV_OFF_IRQ_EN) begin
            irq_en_reg <= hwdata[15:0];
         end
         // Set beats clear: events of this cycle survive a clear.
         if (reg_wr && a_off_reg == `IOV_OFF_IRQ_CLR) begin
            irq_stat_reg <= (irq_stat_reg & ~hwdata[15:0]) | irq_ev;
         end else begin
            irq_stat_reg <= irq_stat_reg | irq_ev;
         end
         irq <= |(irq_stat_reg & irq_en_reg);
      end
   end

   // ****************************************************************
   // Process data paths in both directions.
   // ****************************************************************
   // Words of a channel without a good link and validation are held back.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pd_ctl_valid <= 1'b0;
         pd_ctl_ch <= 3'h0;
         pd_ctl_data <= 16'h0000;
         pd_dev_out_valid <= 1'b0;
         pd_dev_out_ch <= 3'h0;
         pd_dev_out_data <= 16'h0000;
      end else begin
         pd_ctl_valid <= pd_dev_valid && channel_link_up_flags[pd_dev_ch];
         pd_ctl_ch <= pd_dev_ch;
         pd_ctl_data <= swap_word(pd_dev_data, swap_reg[pd_dev_ch]);
         pd_dev_out_valid <= pd_ctl_in_valid && channel_link_up_flags[pd_ctl_in_ch];
         pd_dev_out_ch <= pd_ctl_in_ch;
         pd_dev_out_data <= swap_word(pd_ctl_in_data, swap_reg[pd_ctl_in_ch]);
      end
   end

endmodule

/* File: iov_chk_chk.sv */
// Concurrent checks on the pins of the channel validation block.
`timescale 1ns/100ps
module iov_chk (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [1:0] htrans,
   input wire hready,
   input wire hreadyout,
   input wire [7:0] comm_ok_pin,
   input wire id_report_valid,
   input wire id_report_ready,
   input wire pd_dev_valid,
   input wire [2:0] pd_dev_ch,
   input wire [15:0] pd_dev_data,
   input wire pd_ctl_valid,
   input wire [15:0] pd_ctl_data,
   input wire pd_ctl_in_valid,
   input wire pd_dev_out_valid,
   input wire [7:0] channel_link_up_flags,
   input wire [7:0] channel_line_indicator,
   input wire [7:0] channel_line_fault
);
   // ****************
   // One clock domain; reset silences every check.
   // ****************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_led; channel_line_indicator == channel_link_up_flags; endproperty
   a_led: assert property (p_led) else $error("indicator differs from link");
   property p_excl; (channel_line_fault & channel_link_up_flags) == 8'h00; endproperty
   a_excl: assert property (p_excl) else $error("faulty channel is up");
   property p_loss; !comm_ok_pin[0] [*4] |-> !channel_link_up_flags[0]; endproperty
   a_loss: assert property (p_loss) else $error("lost link still up");
   property p_take; id_report_valid && id_report_ready |=> !id_report_ready; endproperty
   a_take: assert property (p_take) else $error("ready held after take");
   property p_bus; hsel && hready && htrans[1] |=> !hreadyout ##[0:300] hreadyout; endproperty
   a_bus: assert property (p_bus) else $error("bus answer missing");
   property p_pd; pd_dev_valid && channel_link_up_flags[pd_dev_ch]
      && $stable(channel_link_up_flags) |=> pd_ctl_valid; endproperty
   a_pd: assert property (p_pd) else $error("input word lost");
   property p_swap; pd_ctl_valid |-> pd_ctl_data == $past(pd_dev_data)
      || pd_ctl_data == {$past(pd_dev_data[7:0]), $past(pd_dev_data[15:8])}; endproperty
   a_swap: assert property (p_swap) else $error("input word altered");
   property p_src; pd_dev_out_valid |-> $past(pd_ctl_in_valid); endproperty
   a_src: assert property (p_src) else $error("output word from nowhere");
endmodule
bind iov_channel_top iov_chk u_iov_chk (.*);

/* File: iov_dev_model.sv */
// Behavioural IO-Link devices on the eight channels.
`timescale 1ns/100ps
module iov_dev_model (
   input wire hclk,
   output reg id_report_valid,
   output wire [2:0] id_report_ch,
   output wire [15:0] id_report_vendor,
   output wire [31:0] id_report_device,
   output wire [127:0] id_report_serial,
   input wire id_report_ready,
   output reg pd_dev_valid,
   output wire [2:0] pd_dev_ch,
   output wire [15:0] pd_dev_data,
   input wire pd_dev_out_valid,
   input wire [15:0] pd_dev_out_data
);
   reg [178:0] idf; // Identity fields of the pending report.
   reg [18:0] pdf; // Channel and word of the input transfer.
   reg [15:0] out_last; // Last word the block sent to a device.
   integer hung; // Reports the block never took.
   assign {id_report_ch, id_report_vendor, id_report_device, id_report_serial} = idf;
   assign {pd_dev_ch, pd_dev_data} = pdf;
   initial begin
      id_report_valid = 1'b0;
      pd_dev_valid = 1'b0;
      idf = 179'h0;
      pdf = 19'h0;
      out_last = 16'h0000;
      hung = 0;
   end
   // Holds a report until taken or 100 cycles pass; fields turn to garbage after, so stale reuse shows.
   task report(input [2:0] c, input [15:0] v, input [31:0] d, input [127:0] s);
      integer n;
      begin
         id_report_valid <= 1'b1;
         idf <= {c, v, d, s};
         n = 0;
         @(posedge hclk);
         while (id_report_ready !== 1'b1 && n < 100) begin
            @(posedge hclk);
            n = n + 1;
         end
         if (n >= 100)
            hung = hung + 1;
         id_report_valid <= 1'b0;
         idf <= ~{c, v, d, s};
      end
   endtask
   // One input word for a single cycle, then the data lines change.
   task send(input [2:0] c, input [15:0] d);
      begin
         pd_dev_valid <= 1'b1;
         pdf <= {c, d};
         @(posedge hclk);
         pd_dev_valid <= 1'b0;
         pdf <= ~{c, d};
      end
   endtask
   // Keeps the last output word for the bench to inspect.
   always @(posedge hclk) begin
      if (pd_dev_out_valid === 1'b1)
         out_last <= pd_dev_out_data;
   end
endmodule

/* File: testbench.sv */
// Self-checking bench for the channel validation, link and swap block.
`timescale 1ns/100ps
`include "iov_defs.vh"
module testbench;
   // ****************
   // Pins, counters and the last values seen.
   // ****************
   reg hclk, hresetn, hsel, hwrite, pd_ctl_in_valid;
   reg [1:0] htrans;
   reg [2:0] hsize, pd_ctl_in_ch;
   reg [7:0] comm_ok_pin, iolink_mode_pin;
   reg [15:0] pd_ctl_in_data, ctl_last;
   reg [31:0] haddr, hwdata, rd;
   wire hreadyout, hresp, irq, id_report_valid, id_report_ready;
   wire pd_dev_valid, pd_ctl_valid, pd_dev_out_valid;
   wire [2:0] id_report_ch, pd_dev_ch, pd_ctl_ch, pd_dev_out_ch;
   wire [7:0] channel_link_up_flags, channel_line_indicator, channel_line_fault;
   wire [15:0] id_report_vendor, pd_dev_data, pd_ctl_data, pd_dev_out_data;
   wire [31:0] hrdata, id_report_device;
   wire [127:0] id_report_serial;
   integer miscompares, n_tests, i, k;
   localparam [127:0] ser = {32'h53450004, 32'h53450003, 32'h53450002, 32'h53450001};
   localparam [31:0] dev_id = 32'hC0DE0042;
   iov_channel_top u_iov_channel_top (.*, .hready(hreadyout));
   iov_dev_model u_iov_dev_model (.*);
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // Captures each word handed to the controller.
   always @(posedge hclk) begin
      if (pd_ctl_valid === 1'b1)
         ctl_last <= pd_ctl_data;
   end
   function [31:0] wa(input integer c, input integer w);
      wa = 32'h100 + c * 32 + w * 4;
   endfunction
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
            miscompares = miscompares + 1;
         end
      end
   endtask
   task stop_test;
      begin
         $display("%0d compares, %0d mismatches", n_tests, miscompares);
         if (miscompares == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // Waits for hready sampled high at an edge; a hang ends the run.
   task wait_rdy;
      integer n;
      begin
         n = 0;
         @(posedge hclk);
         while (hreadyout !== 1'b1 && n < 400) begin
            @(posedge hclk);
            n = n + 1;
         end
         if (n >= 400) begin
            miscompares = miscompares + 1;
            stop_test;
         end
      end
   endtask
   // One single AHB-Lite transfer; read data lands in rd.
   task xfer(input w, input [31:0] a, input [31:0] d);
      begin
         hsel <= 1'b1;
         htrans <= 2'b10;
         haddr <= a;
         hwrite <= w;
         wait_rdy;
         hsel <= 1'b0;
         htrans <= 2'b00;
         hwdata <= d;
         wait_rdy;
         rd = hrdata;
      end
   endtask
   task rdc(input [31:0] a, input [31:0] e);
      begin
         xfer(1'b0, a, 32'h0);
         chk(rd, e);
      end
   endtask
   // Optionally requests an apply, then polls busy until the engine and the validator are idle.
   task idle(input go);
      integer n;
      begin
         if (go)
            xfer(1'b1, `IOV_OFF_CTRL, 32'h1 << `IOV_CTRL_APPLY_BIT);
         rd = 32'h1;
         for (n = 0; n < 80 && rd[0] !== 1'b0; n = n + 1)
            xfer(1'b0, `IOV_OFF_CTRL, 32'h0);
         if (rd[0] !== 1'b0) begin
            miscompares = miscompares + 1;
            stop_test;
         end
      end
   endtask
   task host_send(input [2:0] c, input [15:0] d);
      begin
         pd_ctl_in_valid <= 1'b1;
         {pd_ctl_in_ch, pd_ctl_in_data} <= {c, d};
         @(posedge hclk);
         pd_ctl_in_valid <= 1'b0;
         {pd_ctl_in_ch, pd_ctl_in_data} <= ~{c, d};
         repeat (3) @(posedge hclk);
      end
   endtask
   initial begin
      {hresetn, hsel, hwrite, pd_ctl_in_valid, htrans} = 6'h00;
      {haddr, hwdata, pd_ctl_in_ch, pd_ctl_in_data, ctl_last} = 99'h0;
      {comm_ok_pin, iolink_mode_pin, hsize} = {8'h00, 8'hFF, 3'b010};
      miscompares = 0;
      n_tests = 0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (i = 0; i < 16; i = i + 1)
         rdc(wa(i / 2, i % 2), 32'h0);
      rdc(32'h80, 32'h0);
      rdc(`IOV_OFF_LINK, 32'h0);
      comm_ok_pin <= 8'hFF;
      repeat (4) @(posedge hclk);
      rdc(`IOV_OFF_LINK, 32'hFF);
      $display("reset test done");
      xfer(1'b1, wa(2, 0), 32'h81);
      u_iov_dev_model.send(3'h2, 16'h12AB);
      repeat (3) @(posedge hclk);
      chk(ctl_last, 16'h12AB);
      idle(1'b1);
      rdc(wa(2, 0), 32'h81);
      u_iov_dev_model.send(3'h2, 16'h12AB);
      repeat (3) @(posedge hclk);
      chk(ctl_last, 16'hAB12);
      host_send(3'h2, 16'h3C5A);
      chk(u_iov_dev_model.out_last, 16'h5A3C);
      host_send(3'h1, 16'h3C5A);
      chk(u_iov_dev_model.out_last, 16'h3C5A);
      $display("swap test done");
      for (i = 0; i < 3; i = i + 1) begin
         xfer(1'b1, wa(i + 3, 1), i);
         xfer(1'b1, wa(i + 3, 2), 32'h1A2B);
         xfer(1'b1, wa(i + 3, 3), dev_id);
         for (k = 0; k < 4; k = k + 1)
            xfer(1'b1, wa(i + 3, k + 4), ser[32 * k +: 32]);
      end
      rdc(`IOV_OFF_LINK, 32'hFF);
      idle(1'b1);
      rdc(`IOV_OFF_LINK, 32'hCF);
      rdc(wa(3, 2), 32'h0);
      rdc(wa(4, 2), 32'h1A2B);
      rdc(wa(5, 7), 32'h53450004);
      chk(hresp, 1'b0);
      u_iov_dev_model.send(3'h4, 16'h7777);
      repeat (3) @(posedge hclk);
      chk(ctl_last, 16'hAB12);
      xfer(1'b1, `IOV_OFF_IRQ_EN, 32'h3000);
      u_iov_dev_model.report(3'h3, 16'hFFFF, 32'h0, 128'h0);
      idle(1'b0);
      u_iov_dev_model.report(3'h4, 16'h1A2C, dev_id, ser);
      idle(1'b0);
      u_iov_dev_model.report(3'h5, 16'h1A2B, dev_id, ser ^ {32'h1, 96'h0});
      idle(1'b0);
      rdc(`IOV_OFF_LINK, 32'h30CF);
      chk(channel_line_indicator, 8'hCF);
      chk(channel_line_fault, 8'h30);
      chk(irq, 1'b1);
      rdc(`IOV_OFF_IRQ_STAT, 32'h3000);
      xfer(1'b1, `IOV_OFF_IRQ_CLR, 32'h3000);
      repeat (3) @(posedge hclk);
      chk(irq, 1'b0);
      u_iov_dev_model.report(3'h4, 16'h1A2B, dev_id, ~ser);
      idle(1'b0);
      u_iov_dev_model.report(3'h5, 16'h1A2B, dev_id, ser);
      idle(1'b0);
      rdc(`IOV_OFF_LINK, 32'hFF);
      $display("validation test done");
      comm_ok_pin <= 8'hFE;
      repeat (5) @(posedge hclk);
      rdc(`IOV_OFF_LINK, 32'hFE);
      rdc(`IOV_OFF_IRQ_STAT, 32'h1);
      chk(irq, 1'b0);
      xfer(1'b1, `IOV_OFF_IRQ_EN, 32'h1);
      repeat (3) @(posedge hclk);
      chk(irq, 1'b1);
      chk(u_iov_dev_model.hung, 32'h0);
      $display("disconnect test done");
      stop_test;
   end
endmodule
